// *** design/mbpf_pkg.sv ***
/*
 * mbpf_pkg: constants, states and carrier types for the binary packet framer.
 * assumes: one 10 MHz system clock; the byte sink is a uart-style valid/ready port.
 */
package mbpf_pkg;

    // clock and millisecond tick
    localparam int CLK_PERIOD_NS = 100;
    localparam int MS_TIME_NS = 1000000;
    localparam int MS_CYCLES = MS_TIME_NS / CLK_PERIOD_NS;

    // packet geometry
    localparam int NUM_CHAN = 18;
    localparam int NUM_GROUPS = 10;
    localparam int HDR_BYTES = 18;
    localparam int TIME_BYTES = 2;
    localparam int CHAN_BYTES = 3;
    localparam int TEMP_BYTES = 2;
    localparam int SUM_BYTES = 4;
    localparam int PAD_BYTES = 6;

    // header field values, packed least significant byte first
    localparam logic [31:0] SYNC_PATTERN = 32'hff00ff00;
    localparam logic [15:0] PACKET_LEN = 16'h027a;
    localparam logic [15:0] STATUS_WORD = 16'h0000;
    localparam logic [15:0] RESERVED_WORD = 16'h0000;
    localparam logic [7:0] PAD_BYTE = 8'h00;

    // reset values
    localparam logic [15:0] MS_RESET = 16'h0000;
    localparam logic [31:0] SUM_RESET = 32'h0000_0000;

    // reference averaging
    localparam int REF_SUM_W = 28;
    localparam logic [27:0] REF_DIVISOR = 28'h000000a;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_HDR,
        ST_GRP,
        ST_REF,
        ST_TMP,
        ST_SUM,
        ST_PAD
    } mbpf_state_t;

    // one finished wheel rotation: signal and reference of every channel,
    // index 0..8 absorption, 9..17 attenuation; 16 integer bits over 8 fraction bits
    typedef struct packed {
        logic [NUM_CHAN-1:0][23:0] sig;
        logic [NUM_CHAN-1:0][23:0] refv;
        logic [15:0] temp;
        logic [15:0] depth;
        logic [15:0] period;
    } mbpf_scan_t;

endpackage

// *** design/mbpf_framer.sv ***
/*
 * mbpf_framer: collects ten wheel rotations, averages their reference values,
 * and streams the binary packet byte by byte to a serial transmitter.
 * assumes: the rotation source pulses scanValid once per rotation, and a packet
 * drains before the next ten rotations complete (about 1.7 s at normal speed).
 */
`timescale 1ns/10ps
`default_nettype none

// Operation
// - every packet opens with bytes 00 ff 00 ff for resynchronisation.
// - two-byte length follows the pattern, excluding checksum and padding.
// - length value is 634 for a complete packet.
// - four-byte serial number follows the length; first two bytes name type.
// - two-byte status follows the serial number, reserved and meaningless.
// - rotation period sent as two-byte count in 31.6 microsecond units.
// - header order: status, period, depth, reserved word, then data.
// - depth sent as raw two-byte sensor count, unscaled.
// - data section is ten groups of 56 bytes: time plus eighteen values.
// - group time is milliseconds since power-on, starting at zero.
// - nine absorption channels first, then nine attenuation channels.
// - each value sent as low integer, high integer, then fraction byte.
// - after the groups, eighteen three-byte reference values, 54 bytes.
// - two-byte raw thermistor temperature follows the reference section.
// - four-byte checksum is the sum of every packet byte; the code sums only the 634 bytes before the checksum.
// - padding bytes follow the checksum, not counted in the length.
// - two-byte integer fields go least significant byte first.
// - reference values are averages over the packet's ten rotations.
// - one data group per wheel rotation, after its data is collected.
module mbpf_framer
    import mbpf_pkg::*;
#(
    parameter int MS_TICK_CYCLES = MS_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // instrument identity
    input wire logic [31:0] serialNum,
    // rotation results
    input wire logic scanValid,
    input wire mbpf_scan_t scan,
    // byte stream toward the uart
    output logic [7:0] txByte,
    output logic txValid,
    input wire logic txReady,
    // status
    output logic packetBusy
);

    // millisecond timestamp
    logic [15:0] msCount_reg;
    logic [31:0] msDiv_reg;
    wire msTick = (msDiv_reg == 32'(MS_TICK_CYCLES - 1));

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            msDiv_reg <= 32'h0000_0000;
            msCount_reg <= MS_RESET;
        end else begin
            msDiv_reg <= msTick ? 32'h0000_0000 : msDiv_reg + 32'h0000_0001;
            if (msTick) begin
                msCount_reg <= msCount_reg + 16'h0001;
            end
        end
    end

    // rotation capture into a double-buffered group store
    logic [23:0] grpMem [2][NUM_GROUPS][NUM_CHAN];
    logic [15:0] timeMem [2][NUM_GROUPS];
    logic wrBank_reg;
    logic rdBank_reg;
    logic [3:0] scanCnt_reg;
    logic pending_reg;
    logic [15:0] tempHold_reg;
    logic [15:0] depthHold_reg;
    logic [15:0] periodHold_reg;
    logic [23:0] refHold [NUM_CHAN];
    logic [REF_SUM_W-1:0] refSum [NUM_CHAN];

    // the tenth rotation closes a packet's worth of groups
    wire lastScan = scanValid && (scanCnt_reg == 4'(NUM_GROUPS - 1));

    genvar gc;
    generate
        for (gc = 0; gc < NUM_CHAN; gc++) begin : g_chan
            wire [REF_SUM_W-1:0] refTotal = refSum[gc] + REF_SUM_W'(scan.refv[gc]);

            always_ff @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    refSum[gc] <= '0;
                    refHold[gc] <= 24'h000000;
                end else if (lastScan) begin
                    refSum[gc] <= '0;
                    refHold[gc] <= 24'(refTotal / REF_DIVISOR);
                end else if (scanValid) begin
                    refSum[gc] <= refTotal;
                end
            end
        end
    endgenerate

    // one process writes the whole store: a rotation's time and all its channels
    always_ff @(posedge clk_sys) begin
        if (scanValid) begin
            timeMem[wrBank_reg][scanCnt_reg] <= msCount_reg;
            for (int c = 0; c < NUM_CHAN; c++) begin
                grpMem[wrBank_reg][scanCnt_reg][c] <= scan.sig[c];
            end
        end
    end

    // transmit sequencing
    mbpf_state_t state_reg, state_next;
    logic [5:0] pos_reg, pos_next;
    logic [4:0] ch_reg, ch_next;
    logic [1:0] bsel_reg, bsel_next;
    logic [3:0] grp_reg, grp_next;
    logic [31:0] sum_reg;
    logic [7:0] txByte_reg;
    logic txValid_reg;
    logic busy_reg;

    wire startPkt = (state_reg == ST_IDLE) && pending_reg;
    // a byte is loaded when the register is empty or being emptied
    wire take = (state_reg != ST_IDLE) && (!txValid_reg || txReady);
    wire bselLast = (bsel_reg == 2'(CHAN_BYTES - 1));
    wire chLast = (ch_reg == 5'(NUM_CHAN - 1));
    wire valLast = bselLast && chLast;
    wire summed = (state_reg == ST_HDR) || (state_reg == ST_GRP)
        || (state_reg == ST_REF) || (state_reg == ST_TMP);

    // rotation counter, bank selection and packet request
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wrBank_reg <= 1'b0;
            rdBank_reg <= 1'b0;
            scanCnt_reg <= 4'h0;
            pending_reg <= 1'b0;
        end else begin
            if (scanValid) begin
                scanCnt_reg <= lastScan ? 4'h0 : scanCnt_reg + 4'h1;
            end
            if (lastScan) begin
                wrBank_reg <= ~wrBank_reg;
            end
            if (startPkt) begin
                rdBank_reg <= wrBank_reg ^ 1'b1;
            end
            // a new request wins over the start that clears the old one
            pending_reg <= lastScan || (pending_reg && !startPkt);
        end
    end

    // header and temperature words of the tenth rotation
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tempHold_reg <= 16'h0000;
            depthHold_reg <= 16'h0000;
            periodHold_reg <= 16'h0000;
        end else if (lastScan) begin
            tempHold_reg <= scan.temp;
            depthHold_reg <= scan.depth;
            periodHold_reg <= scan.period;
        end
    end

    // header bytes, index 0 sent first
    wire [HDR_BYTES-1:0][7:0] hdrBytes = {
        RESERVED_WORD,
        depthHold_reg,
        periodHold_reg,
        STATUS_WORD,
        serialNum,
        PACKET_LEN,
        SYNC_PATTERN
    };

    // channel byte order on the wire: low integer, high integer, fraction
    function automatic logic [7:0] valByte(input logic [23:0] v, input logic [1:0] b);
        logic [7:0] r;
        r = v[7:0];
        if (b == 2'd0) begin
            r = v[15:8];
        end else if (b == 2'd1) begin
            r = v[23:16];
        end
        return r;
    endfunction

    function automatic logic [7:0] wordByte(input logic [15:0] v, input logic hi);
        return hi ? v[15:8] : v[7:0];
    endfunction

    wire [23:0] grpVal = grpMem[rdBank_reg][grp_reg][ch_reg];
    wire [15:0] grpTime = timeMem[rdBank_reg][grp_reg];
    wire inTime = (pos_reg < 6'(TIME_BYTES));
    wire [7:0] grpByte = inTime ? wordByte(grpTime, pos_reg[0]) : valByte(grpVal, bsel_reg);
    wire [7:0] refByte = valByte(refHold[ch_reg], bsel_reg);
    wire [7:0] tmpByte = wordByte(tempHold_reg, pos_reg[0]);
    wire [7:0] sumByte = sum_reg[8*pos_reg[1:0] +: 8];
    wire [7:0] curByte =
        (state_reg == ST_HDR) ? hdrBytes[pos_reg[4:0]] :
        (state_reg == ST_GRP) ? grpByte :
        (state_reg == ST_REF) ? refByte :
        (state_reg == ST_TMP) ? tmpByte :
        (state_reg == ST_SUM) ? sumByte : PAD_BYTE;

    always_comb begin
        state_next = state_reg;
        pos_next = pos_reg;
        ch_next = ch_reg;
        bsel_next = bsel_reg;
        grp_next = grp_reg;
        if (startPkt) begin
            state_next = ST_HDR;
            pos_next = 6'h00;
        end else if (take) begin
            unique case (state_reg)
                ST_HDR: begin
                    pos_next = pos_reg + 6'h01;
                    if (pos_reg == 6'(HDR_BYTES - 1)) begin
                        state_next = ST_GRP;
                        pos_next = 6'h00;
                        grp_next = 4'h0;
                        ch_next = 5'h00;
                        bsel_next = 2'h0;
                    end
                end
                ST_GRP: begin
                    if (inTime) begin
                        pos_next = pos_reg + 6'h01;
                    end else begin
                        bsel_next = bselLast ? 2'h0 : bsel_reg + 2'h1;
                        if (bselLast) begin
                            ch_next = chLast ? 5'h00 : ch_reg + 5'h01;
                        end
                        if (valLast) begin
                            pos_next = 6'h00;
                            grp_next = grp_reg + 4'h1;
                            if (grp_reg == 4'(NUM_GROUPS - 1)) begin
                                state_next = ST_REF;
                                grp_next = 4'h0;
                            end
                        end
                    end
                end
                ST_REF: begin
                    bsel_next = bselLast ? 2'h0 : bsel_reg + 2'h1;
                    if (bselLast) begin
                        ch_next = chLast ? 5'h00 : ch_reg + 5'h01;
                    end
                    if (valLast) begin
                        state_next = ST_TMP;
                        pos_next = 6'h00;
                    end
                end
                ST_TMP: begin
                    pos_next = pos_reg + 6'h01;
                    if (pos_reg == 6'(TEMP_BYTES - 1)) begin
                        state_next = ST_SUM;
                        pos_next = 6'h00;
                    end
                end
                ST_SUM: begin
                    pos_next = pos_reg + 6'h01;
                    if (pos_reg == 6'(SUM_BYTES - 1)) begin
                        state_next = ST_PAD;
                        pos_next = 6'h00;
                    end
                end
                ST_PAD: begin
                    pos_next = pos_reg + 6'h01;
                    if (pos_reg == 6'(PAD_BYTES - 1)) begin
                        state_next = ST_IDLE;
                        pos_next = 6'h00;
                    end
                end
                ST_IDLE: begin
                    state_next = ST_IDLE;
                end
                // the eighth state code is unused; fall back to idle
                default: begin
                    state_next = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_reg <= ST_IDLE;
            pos_reg <= 6'h00;
            ch_reg <= 5'h00;
            bsel_reg <= 2'h0;
            grp_reg <= 4'h0;
        end else begin
            state_reg <= state_next;
            pos_reg <= pos_next;
            ch_reg <= ch_next;
            bsel_reg <= bsel_next;
            grp_reg <= grp_next;
        end
    end

    // busy stays up until the last padding byte has been accepted
    wire busyNext = (state_next != ST_IDLE) || take || (txValid_reg && !txReady);

    // running checksum over every byte before the sum itself
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sum_reg <= SUM_RESET;
        end else if (startPkt) begin
            sum_reg <= SUM_RESET;
        end else if (take && summed) begin
            sum_reg <= sum_reg + {24'h000000, curByte};
        end
    end

    // byte register and busy flag
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            txByte_reg <= 8'h00;
            txValid_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= busyNext;
            if (take) begin
                txByte_reg <= curByte;
                txValid_reg <= 1'b1;
            end else if (txReady) begin
                txValid_reg <= 1'b0;
            end
        end
    end

    assign txByte = txByte_reg;
    assign txValid = txValid_reg;
    assign packetBusy = busy_reg;

endmodule // mbpf_framer

`default_nettype wire

// *** verification/mbpf_chk.sv ***
/* mbpf_chk: assertions on the framer's byte port.
   assumes: bound into mbpf_framer; one clock, async low reset. */
`timescale 1ns/10ps
`default_nettype none
module mbpf_chk
    import mbpf_pkg::*;
#(
    parameter int MS_TICK_CYCLES = MS_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // watched ports
    input wire logic [31:0] serialNum,
    input wire logic [7:0] txByte,
    input wire logic txValid,
    input wire logic txReady,
    input wire logic packetBusy
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    logic [9:0] idx_reg;
    logic [31:0] sum_reg;
    wire logic take = txValid && txReady;
    // serial and checksum both start at an index of 2 modulo 4
    wire logic [4:0] sh = {2'(idx_reg[1:0] - 2'h2), 3'h0};
    wire logic [9:0] idx_next = packetBusy ? idx_reg + 10'(take) : 10'h000;
    wire logic [31:0] sum_next = !packetBusy ? 32'h0 :
        (take && idx_reg < 10'h27a) ? sum_reg + 32'(txByte) : sum_reg;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) {idx_reg, sum_reg} <= 42'h0;
        else {idx_reg, sum_reg} <= {idx_next, sum_next};
    end
    sequence s_start; $rose(packetBusy); endsequence
    sequence s_lead; txValid && txByte == 8'h00; endsequence
    property p_lead; s_start |-> ##[0:1] s_lead; endproperty
    a_lead: assert property (p_lead) else $error("bad first byte");
    property p_sync; take && idx_reg < 10'h004 |-> txByte == {8{idx_reg[0]}}; endproperty
    a_sync: assert property (p_sync) else $error("bad sync");
    property p_len; take && idx_reg[9:1] == 9'h002 |-> txByte == (idx_reg[0] ? 8'h02 : 8'h7a); endproperty
    a_len: assert property (p_len) else $error("bad length");
    property p_ser; take && idx_reg inside {[10'h006:10'h009]} |-> txByte == 8'(serialNum >> sh); endproperty
    a_ser: assert property (p_ser) else $error("bad serial");
    property p_zero; take && idx_reg inside {10'h00a, 10'h00b, 10'h010, 10'h011} |-> txByte == 8'h00; endproperty
    a_zero: assert property (p_zero) else $error("bad zero");
    property p_sum; take && idx_reg inside {[10'h27a:10'h27d]} |-> txByte == 8'(sum_reg >> sh); endproperty
    a_sum: assert property (p_sum) else $error("bad sum");
    property p_end; take && idx_reg == 10'h283 |=> !packetBusy && !txValid; endproperty
    a_end: assert property (p_end) else $error("bad end");
    property p_hold; txValid && !txReady |=> txValid && $stable(txByte); endproperty
    a_hold: assert property (p_hold) else $error("byte dropped");
endmodule // mbpf_chk
bind mbpf_framer mbpf_chk #(.MS_TICK_CYCLES(MS_TICK_CYCLES)) u_chk (.clk_sys, .rstn, .serialNum,
    .txByte, .txValid, .txReady, .packetBusy);
`default_nettype wire

// *** verification/mbpf_host.sv ***
/* mbpf_host: serial host model that collects packet bytes.
   assumes: stallMode picks a receiver ready one cycle in four. */
`timescale 1ns/10ps
`default_nettype none
module mbpf_host (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // byte stream
    input wire logic [7:0] txByte,
    input wire logic txValid,
    output logic txReady,
    // control
    input wire logic stallMode
);
    logic [7:0] rxQ[$];
    logic [1:0] phase;
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            txReady <= 1'b0;
            phase <= 2'h0;
        end else begin
            phase <= phase + 2'h1;
            txReady <= !stallMode || phase == 2'h3;
            if (txValid && txReady) rxQ.push_back(txByte);
        end
    end
endmodule // mbpf_host
`default_nettype wire

// *** verification/tb_top.sv ***
/* tb_top: self-checking bench for the packet framer.
   assumes: mbpf_host at the byte port, mbpf_chk bound. */
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import mbpf_pkg::*;
;
    localparam int TICK = 4;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [31:0] serialNum = 32'h0;
    logic scanValid = 1'b0;
    mbpf_scan_t scan = '0;
    logic stallMode = 1'b0;
    logic [7:0] txByte;
    logic txValid, txReady, packetBusy;
    logic [7:0] eb[644];
    int ptr, err_count = 0, num_checks = 0;
    always #50 clk_sys = ~clk_sys;
    mbpf_framer #(.MS_TICK_CYCLES(TICK)) u_dut (.clk_sys, .rstn, .serialNum, .scanValid, .scan,
        .txByte, .txValid, .txReady, .packetBusy);
    mbpf_host u_host (.clk_sys, .rstn, .txByte, .txValid, .txReady, .stallMode);
    function automatic logic [23:0] sgv(int p, int k, int c, bit r);
        return r ? 24'(c * 24'h011111 + k * 24'h000777 + p) : 24'(p * 24'h000101 + k * 24'h010203 + c);
    endfunction
    function automatic logic [15:0] hv(int p, int k, logic [15:0] b);
        return 16'(b + k * 16'h0011 + p);
    endfunction
    function automatic void put(logic [127:0] v, int n);
        for (int i = 0; i < n; i++) eb[ptr++] = v[8 * i +: 8];
    endfunction
    // channel order on the wire: bits 15:8, 23:16, then the fraction
    function automatic logic [127:0] ord(logic [23:0] v);
        return 128'({v[7:0], v[23:8]});
    endfunction
    task automatic finish_test();
        if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input int idx);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: item %0d got %h want %h", $time, idx, got, exp);
        end
    endtask
    task automatic chk(input int lo, input int hi);
        for (int i = lo; i <= hi; i++) cmp(u_host.rxQ[i], eb[i], i);
    endtask
    task automatic send_pkt(input int p, input int gap);
        u_host.rxQ.delete();
        for (int k = 0; k < NUM_GROUPS; k++) begin
            @(negedge clk_sys);
            for (int c = 0; c < NUM_CHAN; c++) begin
                scan.sig[c] = sgv(p, k, c, 1'b0);
                scan.refv[c] = sgv(p, k, c, 1'b1);
            end
            {scan.temp, scan.depth, scan.period} = {hv(p, k, 16'h0100), hv(p, k, 16'h2000), hv(p, k, 16'h14a0)};
            scanValid = 1'b1;
            @(negedge clk_sys);
            scanValid = 1'b0;
            repeat (gap - 2) @(negedge clk_sys);
        end
    endtask
    task automatic chk_pkt(input int p, input int gap);
        int n, rs;
        logic [15:0] t0;
        logic [31:0] sum;
        for (n = 0; n < 30000 && !(u_host.rxQ.size() == 644 && packetBusy === 1'b0); n++) @(negedge clk_sys);
        cmp(8'(n < 30000), 8'h01, -1);
        if (n == 30000) finish_test();
        t0 = {u_host.rxQ[19], u_host.rxQ[18]};
        ptr = 0;
        put({hv(p, 9, 16'h2000), hv(p, 9, 16'h14a0), 16'h0, serialNum, 16'h027a, 32'hff00ff00}, 16);
        put(128'h0, 2);
        for (int g = 0; g < NUM_GROUPS; g++) begin
            put(128'(t0 + 16'(g * gap / TICK)), 2);
            for (int c = 0; c < NUM_CHAN; c++) put(ord(sgv(p, g, c, 1'b0)), 3);
        end
        for (int c = 0; c < NUM_CHAN; c++) begin
            rs = 0;
            for (int k = 0; k < NUM_GROUPS; k++) rs += int'(sgv(p, k, c, 1'b1));
            put(ord(24'(rs / 10)), 3);
        end
        put(128'(hv(p, 9, 16'h0100)), 2);
        sum = 32'h0;
        for (int i = 0; i < 634; i++) sum += 32'(eb[i]);
        put(128'(sum), 10);
        chk(0, 17);
        for (int g = 0; g < NUM_GROUPS; g++) begin
            chk(18 + 56 * g, 19 + 56 * g);
            chk(20 + 56 * g, 73 + 56 * g);
        end
        chk(578, 633);
        chk(634, 643);
    endtask
    task automatic test_prompt();
        serialNum = 32'h0000_0105;
        send_pkt(0, 8);
        chk_pkt(0, 8);
        cmp(8'({u_host.rxQ[19], u_host.rxQ[18]} <= 16'h0002), 8'h01, 18);
    endtask
    task automatic test_stall();
        serialNum = 32'h1234_abcd;
        stallMode = 1'b1;
        send_pkt(1, 4);
        chk_pkt(1, 4);
    endtask
    initial begin
        repeat (2) @(negedge clk_sys);
        rstn = 1'b1;
        test_prompt();
        test_stall();
        finish_test();
    end
endmodule // tb_top
`default_nettype wire
